//--- pkg/ocm_pkg.sv
// Purpose: shared constants and types for the converter output clocking control
// Assumes: 4-bit register addresses and 16-bit register words on the serial port
// Notes: counts in cycles of mclk (10 MHz)
package ocm_pkg;
   localparam int MCLK_HZ = 10_000_000;
   localparam int MCLK_NS = 1_000_000_000 / MCLK_HZ;

   // register addresses
   localparam logic [3:0] ADDR_OUTPUT_CONFIG = 4'h1;
   localparam logic [3:0] ADDR_INPUT_OFFSET = 4'h2;
   localparam logic [3:0] ADDR_FULL_SCALE = 4'h3;

   // power-on values of the write-only registers
   localparam logic [15:0] OUTPUT_CONFIG_RESET = 16'hB2FF;
   localparam logic [15:0] INPUT_OFFSET_RESET = 16'h0000;
   localparam logic [15:0] FULL_SCALE_RESET = 16'h8000;

   // output_config fields
   localparam int DDR_PHASE_BIT = 11;
   localparam int DDR_DISABLE_BIT = 10;
   localparam int OUTPUT_LEVEL_BIT = 9;
   localparam int LAUNCH_EDGE_BIT = 8;

   // adjust field of the offset and full-scale registers
   localparam int ADJ_LSB = 7;
   localparam int ADJ_MSB = 15;
   localparam int ADJ_W = ADJ_MSB - ADJ_LSB + 1;

   // serial frame: 12 header bits, 4 address bits, 16 data bits, msb first
   localparam logic [11:0] FRAME_HEADER = 12'h001;
   localparam logic [5:0] FRAME_BITS = 6'h20;
   localparam int FRAME_W = 32;

   localparam int WORD_W = 8;
   localparam int PIN_W = 11;

   typedef struct packed {
      logic over_range;
      logic [WORD_W-1:0] bus_d;
      logic [WORD_W-1:0] bus_dd;
   } ocm_word_t;

   // pins that arrive from outside the mclk domain
   typedef struct packed {
      logic power_down_pin;
      logic launch_edge_select_pin;
      logic launch_edge_float;
      logic output_swing_pin;
      logic range_or_ext_ctrl_pin;
      logic range_float;
      logic cal_wait_select;
      logic cal_request_pin;
      logic sclk;
      logic sdata;
      logic scs_n;
   } ocm_pins_t;

   typedef enum logic [1:0] {
      ST_POR_WAIT = 2'b00,
      ST_CAL_RUN = 2'b01,
      ST_ACTIVE = 2'b10,
      ST_POWER_DOWN = 2'b11
   } ocm_state_t;
endpackage

//--- core/ocm_pin_sync.sv
// Purpose: three-stage synchroniser with agreement filter for asynchronous pins
// Assumes: the filtered output moves only when stages two and three agree
// Notes: stage one feeds stage two only
`timescale 1ns/1ns
module ocm_pin_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] INIT = '0
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic [W-1:0] pin_async,
   output logic [W-1:0] pin_level
);
   logic [W-1:0] stage1;
   logic [W-1:0] stage2;
   logic [W-1:0] stage3;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         stage1 <= INIT;
         stage2 <= INIT;
         stage3 <= INIT;
      end else begin
         stage1 <= pin_async;
         stage2 <= stage1;
         stage3 <= stage2;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         pin_level <= INIT;
      end else begin
         for (int i = 0; i < W; i++) begin
            if (stage2[i] == stage3[i]) begin
               pin_level[i] <= stage3[i];
            end
         end
      end
   end
endmodule // ocm_pin_sync

//--- core/ocm_output_ctrl.sv
// Purpose: output clocking, power-down, calibration sequencing and extended control
// Assumes: converter words arrive on mclk; all pins and the serial link are asynchronous
// Notes: the forwarded clock is built from mclk; one word pair per WORD_DIV cycles
`timescale 1ns/1ns
module ocm_output_ctrl
   import ocm_pkg::*;
#(
   parameter int WORD_DIV = 4,
   parameter int CAL_DLY_SHORT = 1024,
   parameter int CAL_DLY_LONG = 8192,
   parameter int CAL_CYCLES = 4096,
   parameter int CAL_LOW_MIN = 80,
   parameter int CAL_HIGH_MIN = 80,
   parameter int PIPE_WORDS = 14
) (
   input wire logic mclk,
   input wire logic nrst,
   input wire ocm_pins_t pins_async,
   input wire ocm_word_t conv_word,
   input wire logic conv_valid,
   output logic conv_ready,
   input wire logic out_ready,
   output ocm_word_t data_out,
   output logic data_oe,
   output logic forwarded_output_clock,
   output logic clock_oe,
   output logic pipeline_valid,
   output logic cal_running,
   output logic ext_mode,
   output logic ddr_active,
   output logic swing_normal,
   output logic fsr_normal,
   output logic [ADJ_W-1:0] full_scale_code,
   output logic [ADJ_W-1:0] offset_code
);
   localparam int HALF_DIV = WORD_DIV / 2;

   function automatic logic reached(input logic [31:0] cnt, input int lim);
      reached = (cnt >= 32'(lim - 1));
   endfunction

   logic rst_q1;
   logic rst_n;
   ocm_pins_t pins;
   ocm_state_t state;
   logic [31:0] wait_cnt;
   logic cal_wait_long;
   logic sclk_prev;
   logic [FRAME_W-1:0] shifter;
   logic [5:0] bit_cnt;
   logic [15:0] output_config;
   logic [15:0] input_offset_adjust;
   logic [15:0] full_scale_adjust;
   logic [31:0] req_cnt;
   logic req_armed;
   logic manual_cal;
   logic [31:0] div_cnt;
   logic launch_tick;
   logic mid_tick;
   logic launch_rising;
   logic ddr_phase90;
   logic [4:0] fresh_cnt;
   ocm_word_t buf_mem [2];
   logic buf_rd;
   logic buf_wr;
   logic [1:0] buf_count;
   logic next_rd;
   logic next_wr;
   logic [1:0] next_count;
   logic take_word;
   logic push;
   logic pop;

   // reset release through two flops
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         rst_q1 <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_q1 <= 1'b1;
         rst_n <= rst_q1;
      end
   end

   ocm_pin_sync #(
      .W(PIN_W),
      .INIT(11'h001)
   ) u_pin_sync (
      .mclk(mclk),
      .rst_n(rst_n),
      .pin_async(pins_async),
      .pin_level(pins)
   );

   // control mode and delay choice are sampled only before calibration starts
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         ext_mode <= 1'b1;
         cal_wait_long <= 1'b0;
      end else if (state == ST_POR_WAIT) begin
         ext_mode <= pins.range_float;
         cal_wait_long <= !pins.range_float && pins.cal_wait_select;
      end
   end

   // serial register writes, sampled on filtered sclk rising edges
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         sclk_prev <= 1'b0;
         shifter <= '0;
         bit_cnt <= '0;
      end else begin
         sclk_prev <= pins.sclk;
         if (pins.scs_n || !ext_mode) begin
            bit_cnt <= '0;
         end else if (pins.sclk && !sclk_prev) begin
            shifter <= {shifter[FRAME_W-2:0], pins.sdata};
            bit_cnt <= (bit_cnt == FRAME_BITS) ? 6'h01 : bit_cnt + 6'h01;
         end
      end
   end

   // power-on values come from the internal reset
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         output_config <= OUTPUT_CONFIG_RESET;
         input_offset_adjust <= INPUT_OFFSET_RESET;
         full_scale_adjust <= FULL_SCALE_RESET;
      end else if (bit_cnt == FRAME_BITS && pins.sclk == sclk_prev
                   && shifter[31:20] == FRAME_HEADER) begin
         if (shifter[19:16] == ADDR_OUTPUT_CONFIG) begin
            output_config <= shifter[15:0];
         end else if (shifter[19:16] == ADDR_INPUT_OFFSET) begin
            input_offset_adjust <= shifter[15:0];
         end else if (shifter[19:16] == ADDR_FULL_SCALE) begin
            full_scale_adjust <= shifter[15:0];
         end
      end
   end

   // manual calibration request: low for CAL_LOW_MIN then high for CAL_HIGH_MIN
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         req_cnt <= '0;
         req_armed <= 1'b0;
         manual_cal <= 1'b0;
      end else if (state != ST_ACTIVE) begin
         req_cnt <= '0;
         req_armed <= 1'b0;
         manual_cal <= 1'b0;
      end else if (!pins.cal_request_pin) begin
         manual_cal <= 1'b0;
         if (req_armed && req_cnt != '0 && !reached(req_cnt, CAL_HIGH_MIN)) begin
            req_armed <= 1'b0;
            req_cnt <= '0;
         end else if (!req_armed && reached(req_cnt, CAL_LOW_MIN)) begin
            req_armed <= 1'b1;
            req_cnt <= '0;
         end else if (!req_armed) begin
            req_cnt <= req_cnt + 32'h1;
         end
      end else if (req_armed) begin
         if (reached(req_cnt, CAL_HIGH_MIN)) begin
            manual_cal <= 1'b1;
            req_armed <= 1'b0;
            req_cnt <= '0;
         end else begin
            req_cnt <= req_cnt + 32'h1;
         end
      end else begin
         req_cnt <= '0;
         manual_cal <= 1'b0;
      end
   end

   // calibration and power state sequence
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         state <= ST_POR_WAIT;
         wait_cnt <= '0;
      end else begin
         case (state)
            ST_POR_WAIT: begin
               if (pins.power_down_pin) begin
                  wait_cnt <= '0;
               end else if (reached(wait_cnt, cal_wait_long ? CAL_DLY_LONG
                                              : CAL_DLY_SHORT)) begin
                  state <= ST_CAL_RUN;
                  wait_cnt <= '0;
               end else begin
                  wait_cnt <= wait_cnt + 32'h1;
               end
            end
            ST_CAL_RUN: begin
               if (reached(wait_cnt, CAL_CYCLES)) begin
                  state <= pins.power_down_pin ? ST_POWER_DOWN : ST_ACTIVE;
                  wait_cnt <= '0;
               end else begin
                  wait_cnt <= wait_cnt + 32'h1;
               end
            end
            ST_ACTIVE: begin
               wait_cnt <= '0;
               if (pins.power_down_pin) begin
                  state <= ST_POWER_DOWN;
               end else if (manual_cal) begin
                  state <= ST_CAL_RUN;
               end
            end
            ST_POWER_DOWN: begin
               wait_cnt <= '0;
               if (!pins.power_down_pin) begin
                  state <= ST_ACTIVE;
               end
            end
            default: begin
               state <= ST_POR_WAIT;
            end
         endcase
      end
   end

   // effective output settings
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         ddr_active <= 1'b1;
         launch_rising <= 1'b0;
         ddr_phase90 <= 1'b0;
         swing_normal <= 1'b1;
         fsr_normal <= 1'b1;
         full_scale_code <= '0;
         offset_code <= '0;
      end else if (ext_mode) begin
         ddr_active <= !output_config[DDR_DISABLE_BIT];
         launch_rising <= output_config[LAUNCH_EDGE_BIT];
         ddr_phase90 <= output_config[DDR_PHASE_BIT];
         swing_normal <= output_config[OUTPUT_LEVEL_BIT];
         fsr_normal <= 1'b1;
         full_scale_code <= full_scale_adjust[ADJ_MSB:ADJ_LSB];
         offset_code <= input_offset_adjust[ADJ_MSB:ADJ_LSB];
      end else begin
         ddr_active <= pins.launch_edge_float;
         launch_rising <= pins.launch_edge_select_pin;
         ddr_phase90 <= 1'b0;
         swing_normal <= pins.output_swing_pin;
         fsr_normal <= pins.range_or_ext_ctrl_pin;
         full_scale_code <= '0;
         offset_code <= '0;
      end
   end

   // word timing: launch at count zero, mid point half a word later
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         div_cnt <= '0;
      end else if (state != ST_ACTIVE) begin
         div_cnt <= '0;
      end else begin
         div_cnt <= reached(div_cnt, WORD_DIV) ? '0 : div_cnt + 32'h1;
      end
   end

   assign launch_tick = (state == ST_ACTIVE) && (div_cnt == '0);
   assign mid_tick = (state == ST_ACTIVE) && (div_cnt == 32'(HALF_DIV));

   // forwarded clock: clocks are halted during calibration
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         forwarded_output_clock <= 1'b0;
      end else if (ddr_active) begin
         if (ddr_phase90 ? mid_tick : launch_tick) begin
            forwarded_output_clock <= !forwarded_output_clock;
         end
      end else if (launch_tick) begin
         forwarded_output_clock <= launch_rising;
      end else if (mid_tick) begin
         forwarded_output_clock <= !launch_rising;
      end
   end

   // pins float in power-down and before the first calibration starts
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         data_oe <= 1'b0;
         clock_oe <= 1'b0;
         cal_running <= 1'b0;
      end else begin
         cal_running <= (state == ST_CAL_RUN);
         data_oe <= (state == ST_ACTIVE) || (state == ST_CAL_RUN);
         clock_oe <= (state == ST_ACTIVE) || (state == ST_CAL_RUN);
      end
   end

   // two-entry buffer between converter and launch register
   assign take_word = launch_tick && out_ready;
   assign push = conv_valid && conv_ready;
   assign pop = take_word && (buf_count != 2'h0);

   always_comb begin
      next_wr = push ? !buf_wr : buf_wr;
      next_rd = pop ? !buf_rd : buf_rd;
      next_count = buf_count;
      if (push && !pop) begin
         next_count = buf_count + 2'h1;
      end else if (pop && !push) begin
         next_count = buf_count - 2'h1;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         buf_wr <= 1'b0;
         buf_rd <= 1'b0;
         buf_count <= 2'h0;
         conv_ready <= 1'b0;
      end else begin
         buf_wr <= next_wr;
         buf_rd <= next_rd;
         buf_count <= next_count;
         conv_ready <= (next_count != 2'h2);
      end
   end

   always_ff @(posedge mclk) begin
      if (push) begin
         buf_mem[buf_wr] <= conv_word;
      end
   end

   // launch register and refill tracking
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         data_out <= '0;
         fresh_cnt <= '0;
         pipeline_valid <= 1'b0;
      end else if (state != ST_ACTIVE) begin
         fresh_cnt <= '0;
         pipeline_valid <= 1'b0;
      end else if (pop) begin
         data_out <= buf_mem[buf_rd];
         if (fresh_cnt == 5'(PIPE_WORDS)) begin
            pipeline_valid <= 1'b1;
         end else begin
            fresh_cnt <= fresh_cnt + 5'h01;
         end
      end
   end
endmodule // ocm_output_ctrl

//--- tb/ocm_rx_model.sv
// Purpose: receiver latching launched words on the forwarded clock
// Assumes: set to the same rate and edge as the device
// Notes: a repeat of the last stored word is not stored again
`timescale 1ns/1ns
module ocm_rx_model
   import ocm_pkg::*;
(
   input wire logic mclk,
   input wire logic fclk,
   input wire ocm_word_t data,
   input wire logic data_oe,
   input wire logic pipeline_valid,
   input wire logic ddr,
   input wire logic launch_rising,
   input wire logic stall,
   output logic out_ready
);
   ocm_word_t cap[$];
   logic [2:0] cnt = 3'h0;
   initial out_ready = 1'b1;
   // slow mode holds off launches four cycles in eight
   always @(posedge mclk) begin
      cnt <= cnt + 3'h1;
      out_ready <= !stall || cnt[2];
   end
   always @(fclk) begin
      #1;
      if (data_oe && pipeline_valid && (ddr || fclk == !launch_rising)) begin
         if (cap.size() == 0 || cap[$] !== data)
            cap.push_back(data);
      end
   end
endmodule // ocm_rx_model

//--- tb/ocm_output_ctrl_properties.sv
// Purpose: port checks of output clocking and power-down
// Assumes: pins held steady while a mode is in use
// Notes: bound to ocm_output_ctrl
`timescale 1ns/1ns
module ocm_output_ctrl_properties
   import ocm_pkg::*;
(
   input wire logic mclk,
   input wire logic nrst,
   input wire ocm_pins_t pins_async,
   input wire ocm_word_t data_out,
   input wire logic data_oe,
   input wire logic forwarded_output_clock,
   input wire logic clock_oe,
   input wire logic pipeline_valid,
   input wire logic ext_mode,
   input wire logic ddr_active,
   input wire logic swing_normal,
   input wire logic fsr_normal,
   input wire logic [ADJ_W-1:0] full_scale_code,
   input wire logic [ADJ_W-1:0] offset_code
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!nrst);
   logic sdr_seen;
   // set once a launch has happened in sdr, so the clock phase is settled
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst)
         sdr_seen <= 1'b0;
      else
         sdr_seen <= !ddr_active && pipeline_valid && (sdr_seen || $changed(data_out));
   end
   property p_por_defaults;
      $rose(nrst) |-> ext_mode && ddr_active && swing_normal && fsr_normal && !data_oe;
   endproperty
   a_por_defaults: assert property (p_por_defaults) else $error("bad power-on state");
   property p_oe_pair;
      data_oe == clock_oe;
   endproperty
   a_oe_pair: assert property (p_oe_pair) else $error("enables differ");
   property p_oe_pd_low;
      $rose(data_oe) |-> !$past(pins_async.power_down_pin, 2);
   endproperty
   a_oe_pd_low: assert property (p_oe_pd_low) else $error("enabled in power-down");
   property p_pin_no_adjust;
      !ext_mode ##1 !ext_mode |-> offset_code == '0 && full_scale_code == '0;
   endproperty
   a_pin_no_adjust: assert property (p_pin_no_adjust) else $error("adjust in pin mode");
   property p_mode_fixed;
      data_oe && $past(data_oe) |-> $stable(ext_mode);
   endproperty
   a_mode_fixed: assert property (p_mode_fixed) else $error("mode moved");
   property p_pipe_refill;
      $rose(data_oe) |-> !pipeline_valid;
   endproperty
   a_pipe_refill: assert property (p_pipe_refill) else $error("stale pipeline valid");
   property p_quiet_off;
      !data_oe ##1 !data_oe |-> $stable(data_out);
   endproperty
   a_quiet_off: assert property (p_quiet_off) else $error("launch while off");
   property p_sdr_clock;
      sdr_seen && !ddr_active && $changed(data_out) |-> $changed(forwarded_output_clock);
   endproperty
   a_sdr_clock: assert property (p_sdr_clock) else $error("sdr launch without edge");
   property p_pin_sdr_edge;
      !ext_mode && !ddr_active && pipeline_valid && $past(pipeline_valid) && $changed(data_out)
         |-> forwarded_output_clock == pins_async.launch_edge_select_pin;
   endproperty
   a_pin_sdr_edge: assert property (p_pin_sdr_edge) else $error("wrong sdr edge");
   property p_pin_ddr_phase;
      !ext_mode && ddr_active && pipeline_valid && $past(pipeline_valid) && $changed(data_out)
         |-> $changed(forwarded_output_clock);
   endproperty
   a_pin_ddr_phase: assert property (p_pin_ddr_phase) else $error("ddr phase not 0");
endmodule // ocm_output_ctrl_properties
bind ocm_output_ctrl ocm_output_ctrl_properties u_props (.mclk(mclk), .nrst(nrst),
   .pins_async(pins_async), .data_out(data_out), .data_oe(data_oe),
   .forwarded_output_clock(forwarded_output_clock), .clock_oe(clock_oe),
   .pipeline_valid(pipeline_valid), .ext_mode(ext_mode), .ddr_active(ddr_active),
   .swing_normal(swing_normal), .fsr_normal(fsr_normal),
   .full_scale_code(full_scale_code), .offset_code(offset_code));

//--- tb/adc_output_clocking_and_control_modes_tb_top.sv
// Purpose: self-checking bench for ocm_output_ctrl
// Assumes: shortened calibration counts
// Notes: mode rows first, then power-down and serial cases
`timescale 1ns/1ns
module adc_output_clocking_and_control_modes_tb_top;
   import ocm_pkg::*;
   localparam int D = 5;
   localparam int DLY_S = 16;
   localparam int DLY_L = 32;
   localparam int CAL_N = 20;
   // range_float edge_float edge_pin swing range cal_wait | ext ddr swing fsr long
   localparam logic [10:0] ROWS [4] = '{11'h43E, 11'h2CE, 11'h100, 11'h0E7};
   logic mclk = 1'b0;
   logic nrst = 1'b0;
   ocm_pins_t pins;
   ocm_word_t conv_word = '0;
   logic conv_valid = 1'b0;
   logic stall = 1'b0;
   logic rx_ddr = 1'b1;
   logic rx_rise = 1'b0;
   logic conv_ready, out_ready, data_oe, fclk, clock_oe, pipeline_valid, c, cal_running;
   logic ext_mode, ddr_active, swing_normal, fsr_normal;
   ocm_word_t data_out;
   logic [ADJ_W-1:0] full_scale_code, offset_code;
   ocm_word_t sent[$];
   int num_errors = 0;
   int checks_done = 0;
   int n;
   wire ocm_word_t pin_data = data_oe ? data_out : 'z;
   wire logic pin_clk = clock_oe ? fclk : 1'bz;
   always #50 mclk = ~mclk;
   ocm_output_ctrl #(.WORD_DIV(4), .CAL_DLY_SHORT(DLY_S), .CAL_DLY_LONG(DLY_L),
      .CAL_CYCLES(CAL_N), .CAL_LOW_MIN(4), .CAL_HIGH_MIN(4), .PIPE_WORDS(4)) u_dut (
      .mclk(mclk), .nrst(nrst), .pins_async(pins), .conv_word(conv_word),
      .conv_valid(conv_valid), .conv_ready(conv_ready), .out_ready(out_ready),
      .data_out(data_out), .data_oe(data_oe), .forwarded_output_clock(fclk),
      .clock_oe(clock_oe), .pipeline_valid(pipeline_valid), .cal_running(cal_running),
      .ext_mode(ext_mode), .ddr_active(ddr_active), .swing_normal(swing_normal),
      .fsr_normal(fsr_normal), .full_scale_code(full_scale_code), .offset_code(offset_code));
   ocm_rx_model u_rx (.mclk(mclk), .fclk(pin_clk), .data(pin_data), .data_oe(data_oe),
      .pipeline_valid(pipeline_valid), .ddr(rx_ddr), .launch_rising(rx_rise),
      .stall(stall), .out_ready(out_ready));
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         num_errors++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic give_verdict();
      $display("errors %0d checks %0d", num_errors, checks_done);
      if (num_errors == 0 && checks_done > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic tick(input int k);
      repeat (k) @(posedge mclk);
      #D;
   endtask
   task automatic bound(input int k);
      if (k == 400) begin
         num_errors++;
         $display("[FAIL] %0t wait ran out", $time);
         give_verdict();
      end
   endtask
   task automatic do_reset();
      nrst = 1'b0;
      tick(5);
      nrst = 1'b1;
   endtask
   task automatic wait_oe(input logic lvl, output int k);
      for (k = 0; data_oe !== lvl; k++) begin
         bound(k);
         tick(1);
      end
   endtask
   // word is held until ready is seen at an edge
   task automatic push(input ocm_word_t w);
      conv_word = w;
      conv_valid = 1'b1;
      for (n = 0; conv_ready !== 1'b1; n++) begin
         bound(n);
         tick(1);
      end
      tick(1);
      sent.push_back(w);
   endtask
   task automatic stream(input int cnt);
      sent.delete();
      u_rx.cap.delete();
      for (int k = 0; k < cnt; k++)
         push({1'b0, 8'(k * 37 + 5), 8'(k ^ 8'hA5)});
      conv_valid = 1'b0;
      for (n = 0; !(u_rx.cap.size() > 0 && u_rx.cap[$] === sent[$]); n++) begin
         bound(n);
         tick(1);
      end
      chk(u_rx.cap.size() >= 6, 1);
      for (int j = 1; j <= 6; j++)
         chk(u_rx.cap[u_rx.cap.size() - j], sent[cnt - j]);
   endtask
   // serial link clock stands low outside frames
   task automatic sframe(input logic [31:0] f);
      pins.scs_n = 1'b0;
      for (int b = 31; b >= 0; b--) begin
         pins.sdata = f[b];
         tick(4);
         pins.sclk = 1'b1;
         tick(4);
         pins.sclk = 1'b0;
      end
      tick(4);
      pins.scs_n = 1'b1;
      tick(12);
   endtask
   initial begin
      pins = '0;
      pins.scs_n = 1'b1;
      pins.cal_request_pin = 1'b1;
      for (int i = 0; i < 4; i++) begin
         {pins.range_float, pins.launch_edge_float, pins.launch_edge_select_pin,
            pins.output_swing_pin, pins.range_or_ext_ctrl_pin,
            pins.cal_wait_select} = ROWS[i][10:5];
         rx_ddr = ROWS[i][3];
         rx_rise = ROWS[i][8];
         stall = i[0];
         do_reset();
         wait_oe(1'b1, n);
         chk(n >= DLY_L, ROWS[i][0]);
         chk({ext_mode, ddr_active, swing_normal, fsr_normal}, ROWS[i][4:1]);
         stream(12);
      end
      sframe({FRAME_HEADER, ADDR_INPUT_OFFSET, 16'hAB80});
      chk(offset_code, 0);
      {pins.range_float, pins.power_down_pin} = 2'b11;
      rx_ddr = 1'b1;
      stall = 1'b0;
      do_reset();
      tick(60);
      chk(data_oe, 0);
      pins.power_down_pin = 1'b0;
      wait_oe(1'b1, n);
      chk(n >= DLY_S, 1);
      chk(cal_running, 1);
      pins.power_down_pin = 1'b1;
      wait_oe(1'b0, n);
      chk(n >= CAL_N - 2, 1);
      chk(clock_oe, 0);
      chk(cal_running, 0);
      sent.delete();
      push(17'h1A5A5);
      push(17'h0C3C3);
      conv_valid = 1'b0;
      chk(conv_ready, 0);
      pins.cal_request_pin = 1'b0;
      tick(8);
      pins.cal_request_pin = 1'b1;
      tick(8);
      pins.power_down_pin = 1'b0;
      wait_oe(1'b1, n);
      chk(pipeline_valid, 0);
      c = fclk;
      for (n = 0; fclk === c && n < 40; n++)
         tick(1);
      chk(n < CAL_N, 1);
      chk(cal_running, 0);
      sframe({FRAME_HEADER, ADDR_OUTPUT_CONFIG, 16'hB5FF});
      chk({ddr_active, swing_normal}, 0);
      rx_ddr = 1'b0;
      rx_rise = 1'b1;
      stream(12);
      sframe({FRAME_HEADER, ADDR_INPUT_OFFSET, 16'hAB80});
      sframe({FRAME_HEADER, ADDR_FULL_SCALE, 16'h4000});
      sframe({FRAME_HEADER, 4'h4, 16'hFFFF});
      sframe({12'h003, ADDR_OUTPUT_CONFIG, 16'hB2FF});
      chk({offset_code, full_scale_code, ddr_active}, {9'h157, 9'h080, 1'b0});
      // a request while active must start a calibration
      pins.cal_request_pin = 1'b0;
      tick(8);
      pins.cal_request_pin = 1'b1;
      for (n = 0; cal_running !== 1'b1 && n < 40; n++)
         tick(1);
      chk(n < 40, 1);
      give_verdict();
   end
endmodule // adc_output_clocking_and_control_modes_tb_top
